// >>> rtl/calmux_pkg.sv
// constants for the calibration source and input mux block
package calmux_pkg;

  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int REG_W  = 24;
  localparam int CNT_W  = 22;
  localparam int HIGH_W = 11;
  localparam int FREQ_W = 3;

  // register indices; byte address is four times the index
  localparam logic [5:0] CAL_CFG_IDX  = 6'h12;
  localparam logic [5:0] CAL_STAT_IDX = 6'h13;
  localparam logic [5:0] EMUX_CFG_IDX = 6'h14;
  localparam logic [APB_AW-1:0] CAL_CFG_ADDR  = {CAL_CFG_IDX, 2'h0};
  localparam logic [APB_AW-1:0] CAL_STAT_ADDR = {CAL_STAT_IDX, 2'h0};
  localparam logic [APB_AW-1:0] EMUX_CFG_ADDR = {EMUX_CFG_IDX, 2'h0};

  // calibration_source_config fields
  localparam int CAL_EN_BIT    = 22;
  localparam int CAL_MODE_BIT  = 21;
  localparam int CAL_MAG_BIT   = 20;
  localparam int CAL_FREQ_LSB  = 12;
  localparam int CAL_HALF_BIT  = 11;
  localparam int CAL_HIGH_LSB  = 0;
  localparam logic [REG_W-1:0] CAL_CFG_RST  = 24'h004800;
  localparam logic [REG_W-1:0] CAL_CFG_MASK = 24'h707FFF;

  // ecg_input_mux_config fields
  localparam int EMUX_INV_BIT    = 23;
  localparam int EMUX_ISOP_BIT   = 21;
  localparam int EMUX_ISON_BIT   = 20;
  localparam int EMUX_ROUTEP_LSB = 18;
  localparam int EMUX_ROUTEN_LSB = 16;
  localparam logic [REG_W-1:0] EMUX_CFG_RST  = 24'h300000;
  localparam logic [REG_W-1:0] EMUX_CFG_MASK = 24'hBF0000;

  // status register fields
  localparam int STAT_RES_LSB   = 0;
  localparam int STAT_FSEL_LSB  = 16;
  localparam int STAT_LVLP_LSB  = 18;
  localparam int STAT_LVLN_LSB  = 20;
  localparam int STAT_PHASE_BIT = 22;

  // input calibration routes
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_MID  = 2'h1;
  localparam logic [1:0] ROUTE_CALP = 2'h2;
  localparam logic [1:0] ROUTE_CALN = 2'h3;

  // source level codes
  localparam logic [1:0] LEVEL_MID   = 2'h0;
  localparam logic [1:0] LEVEL_PLUS  = 2'h1;
  localparam logic [1:0] LEVEL_MINUS = 2'h2;

  // period is two to this power, in master clock ticks
  localparam logic [4:0] FREQ_SHIFT [8] = '{5'h07, 5'h09, 5'h0B, 5'h0D,
                                           5'h0F, 5'h11, 5'h13, 5'h15};

  // timing resolution per master frequency selection, in ns
  localparam logic [15:0] CAL_TIMING_RESOLUTION_NS [4] = '{16'h7738, 16'h7A12, 16'h7A12, 16'h7A30};

endpackage : calmux_pkg

// >>> rtl/calmux_top.sv
// calibration source control and ecg input mux registers behind apb
//
// Notes on behaviour
// - calibration enable off disables both sources, on lets them run per the other settings.
// - mode 0 swings sources between midpoint and one offset, mode 1 between plus and minus.
// - the magnitude bit selects 0.25mV when 0 and 0.50mV when 1.
// - the frequency code divides the master frequency by 128 up to 2^21 in steps of four.
// - waveform timing scales with the master clock rather than fixed values.
// - half duty mode gives a high time of half the period and ignores the count.
// - otherwise the high time is the 11-bit count times the timing resolution.
// - the invert bit leaves the channel non-inverted at 0 and inverts it at 1.
// - the positive isolate bit connects at 0, isolates at 1, and resets isolated.
// - the negative isolate bit connects at 0, isolates at 1, and resets isolated.
// - positive input route applies none, midpoint, positive or negative source.
// - negative input route applies none, midpoint, positive or negative source.
// - routes to a calibration source act only while calibration is enabled.
// - the timing resolution follows the master frequency selection.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module calmux_top
  import calmux_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              masterClk,
  input  wire logic [1:0]        masterFreqSelect,
  output logic                   calSourceEnable,
  output logic                   calAmplitudeSelect,
  output logic      [1:0]        calSourcePosLevel,
  output logic      [1:0]        calSourceNegLevel,
  output logic                   inputInvert,
  output logic                   posInputIsolate,
  output logic                   negInputIsolate,
  output logic      [1:0]        posInputCalRoute,
  output logic      [1:0]        negInputCalRoute
);

  typedef struct packed {
    logic [REG_W-1:0]  calCfg;
    logic [REG_W-1:0]  emuxCfg;
    logic [APB_DW-1:0] rdata;
    logic [2:0]        sync;
    logic              mclkLevel;
    logic              calEn;
    logic              calMag;
    logic [1:0]        levelPos;
    logic [1:0]        levelNeg;
    logic              invert;
    logic              isoPos;
    logic              isoNeg;
    logic [1:0]        routePos;
    logic [1:0]        routeNeg;
  } calmux_top_st_t;

  calmux_top_st_t    state_reg;
  calmux_top_st_t    state_next;
  logic              setupPhase;
  logic              accessPhase;
  logic              mapped;
  logic              wrCal;
  logic              wrEmux;
  logic              mclkTick;
  logic              phaseHigh;
  logic [APB_DW-1:0] readValue;
  logic [REG_W-1:0]  statusWord;
  logic              calEnBit;
  logic              calModeBit;
  logic [1:0]        cfgRouteP;
  logic [1:0]        cfgRouteN;

  assign calEnBit   = state_reg.calCfg[CAL_EN_BIT];
  assign calModeBit = state_reg.calCfg[CAL_MODE_BIT];
  assign cfgRouteP  = state_reg.emuxCfg[EMUX_ROUTEP_LSB +: 2];
  assign cfgRouteN  = state_reg.emuxCfg[EMUX_ROUTEN_LSB +: 2];

  // apb decode, zero wait states
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign mapped      = (paddr == CAL_CFG_ADDR) || (paddr == EMUX_CFG_ADDR)
                       || (paddr == CAL_STAT_ADDR);
  assign wrCal       = accessPhase && pwrite && (paddr == CAL_CFG_ADDR);
  assign wrEmux      = accessPhase && pwrite && (paddr == EMUX_CFG_ADDR);
  assign pready      = accessPhase;
  assign pslverr     = accessPhase && !mapped;
  assign prdata      = state_reg.rdata;

  // master clock edge, counted once stages two and three agree
  assign mclkTick = (state_reg.sync[1] == state_reg.sync[2])
                    && state_reg.sync[2] && !state_reg.mclkLevel;

  always_comb begin
    statusWord = '0;
    statusWord[STAT_RES_LSB +: 16]  = CAL_TIMING_RESOLUTION_NS[masterFreqSelect];
    statusWord[STAT_FSEL_LSB +: 2]  = masterFreqSelect;
    statusWord[STAT_LVLP_LSB +: 2]  = state_reg.levelPos;
    statusWord[STAT_LVLN_LSB +: 2]  = state_reg.levelNeg;
    statusWord[STAT_PHASE_BIT]      = phaseHigh;
  end

  always_comb begin
    case (paddr)
      CAL_CFG_ADDR:  readValue = APB_DW'(state_reg.calCfg);
      EMUX_CFG_ADDR: readValue = APB_DW'(state_reg.emuxCfg);
      CAL_STAT_ADDR: readValue = APB_DW'(statusWord);
      default:       readValue = '0;
    endcase
  end

  always_comb begin
    state_next = state_reg;

    // register writes land at the access edge
    if (wrCal) begin
      state_next.calCfg = pwdata[REG_W-1:0] & CAL_CFG_MASK;
    end
    if (wrEmux) begin
      state_next.emuxCfg = pwdata[REG_W-1:0] & EMUX_CFG_MASK;
    end
    if (setupPhase) begin
      state_next.rdata = readValue;
    end

    // master clock synchroniser and stable level
    state_next.sync = {state_reg.sync[1:0], masterClk};
    if (state_reg.sync[1] == state_reg.sync[2]) begin
      state_next.mclkLevel = state_reg.sync[2];
    end

    // source controls
    state_next.calEn  = calEnBit;
    state_next.calMag = state_reg.calCfg[CAL_MAG_BIT];
    if (!calEnBit) begin
      state_next.levelPos = LEVEL_MID;
      state_next.levelNeg = LEVEL_MID;
    end else if (calModeBit) begin
      state_next.levelPos = phaseHigh ? LEVEL_PLUS : LEVEL_MINUS;
      state_next.levelNeg = phaseHigh ? LEVEL_MINUS : LEVEL_PLUS;
    end else begin
      state_next.levelPos = phaseHigh ? LEVEL_PLUS : LEVEL_MID;
      state_next.levelNeg = phaseHigh ? LEVEL_MINUS : LEVEL_MID;
    end

    // input mux controls
    state_next.invert = state_reg.emuxCfg[EMUX_INV_BIT];
    state_next.isoPos = state_reg.emuxCfg[EMUX_ISOP_BIT];
    state_next.isoNeg = state_reg.emuxCfg[EMUX_ISON_BIT];
    state_next.routePos = (cfgRouteP[1] && !calEnBit) ? ROUTE_NONE : cfgRouteP;
    state_next.routeNeg = (cfgRouteN[1] && !calEnBit) ? ROUTE_NONE : cfgRouteN;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg          <= '0;
      state_reg.calCfg   <= CAL_CFG_RST;
      state_reg.emuxCfg  <= EMUX_CFG_RST;
      state_reg.isoPos   <= 1'b1;
      state_reg.isoNeg   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  calmux_wave_gen u_wave_gen (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .enable    (calEnBit),
    .tick      (mclkTick),
    .divSel    (state_reg.calCfg[CAL_FREQ_LSB +: FREQ_W]),
    .halfDuty  (state_reg.calCfg[CAL_HALF_BIT]),
    .highCount (state_reg.calCfg[CAL_HIGH_LSB +: HIGH_W]),
    .phaseHigh (phaseHigh)
  );

  assign calSourceEnable    = state_reg.calEn;
  assign calAmplitudeSelect = state_reg.calMag;
  assign calSourcePosLevel  = state_reg.levelPos;
  assign calSourceNegLevel  = state_reg.levelNeg;
  assign inputInvert        = state_reg.invert;
  assign posInputIsolate    = state_reg.isoPos;
  assign negInputIsolate    = state_reg.isoNeg;
  assign posInputCalRoute   = state_reg.routePos;
  assign negInputCalRoute   = state_reg.routeNeg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence seq_cal_off;
    !calEnBit [*2];
  endsequence

  sequence seq_bipolar_on;
    (calEnBit && calModeBit) [*2];
  endsequence

  sequence seq_unipolar_on;
    (calEnBit && !calModeBit) [*2];
  endsequence

  sequence seq_read_setup;
    setupPhase && !pwrite;
  endsequence

  sequence seq_bad_write;
    accessPhase && pwrite && !mapped;
  endsequence

  property p_follow_bit(logic cfgBit, logic outBit);
    1'b1 |=> outBit == $past(cfgBit);
  endproperty

  route_gate_a: assert property (!calEnBit |=> !posInputCalRoute[1]
                                 && !negInputCalRoute[1])
    else $error("source route passed while calibration disabled");

  route_pass_a: assert property (calEnBit |=> posInputCalRoute == $past(cfgRouteP)
                                 && negInputCalRoute == $past(cfgRouteN))
    else $error("route not passed while calibration enabled");

  off_mid_a: assert property (seq_cal_off |-> calSourcePosLevel == LEVEL_MID
                              && calSourceNegLevel == LEVEL_MID
                              && !calSourceEnable)
    else $error("sources not at midpoint while disabled");

  bipolar_swing_a: assert property (seq_bipolar_on |=> calSourcePosLevel != LEVEL_MID
                                    && calSourceNegLevel != LEVEL_MID
                                    && calSourceNegLevel != calSourcePosLevel)
    else $error("bipolar levels wrong");

  unipolar_swing_a: assert property (seq_unipolar_on |=> calSourcePosLevel != LEVEL_MINUS
                                     && calSourceNegLevel != LEVEL_PLUS)
    else $error("unipolar levels wrong");

  amplitude_sel_a: assert property (p_follow_bit(state_reg.calCfg[CAL_MAG_BIT],
                                                 calAmplitudeSelect))
    else $error("amplitude select does not follow register");

  invert_sel_a: assert property (p_follow_bit(state_reg.emuxCfg[EMUX_INV_BIT],
                                              inputInvert))
    else $error("input invert does not follow register");

  isolate_pos_a: assert property (p_follow_bit(state_reg.emuxCfg[EMUX_ISOP_BIT],
                                               posInputIsolate))
    else $error("positive isolate does not follow register");

  isolate_neg_a: assert property (p_follow_bit(state_reg.emuxCfg[EMUX_ISON_BIT],
                                               negInputIsolate))
    else $error("negative isolate does not follow register");

  cal_write_a: assert property (wrCal |=> state_reg.calCfg
                                == ($past(pwdata[REG_W-1:0]) & CAL_CFG_MASK))
    else $error("calibration register write lost");

  resolution_a: assert property (setupPhase && !pwrite && paddr == CAL_STAT_ADDR
                                 |=> prdata[STAT_RES_LSB +: 16]
                                     == CAL_TIMING_RESOLUTION_NS[$past(masterFreqSelect)]
                                 && prdata[STAT_FSEL_LSB +: 2]
                                     == $past(masterFreqSelect))
    else $error("resolution readback wrong");

  emux_write_a: assert property (wrEmux |=> state_reg.emuxCfg
                                 == ($past(pwdata[REG_W-1:0]) & EMUX_CFG_MASK))
    else $error("input mux register write lost");

  cal_readback_a: assert property (seq_read_setup ##0 paddr == CAL_CFG_ADDR
                                   |=> prdata == APB_DW'($past(state_reg.calCfg)))
    else $error("calibration register readback wrong");

  emux_readback_a: assert property (seq_read_setup ##0 paddr == EMUX_CFG_ADDR
                                    |=> prdata == APB_DW'($past(state_reg.emuxCfg)))
    else $error("input mux register readback wrong");

  unmapped_read_a: assert property (seq_read_setup ##0 !mapped |=> prdata == '0)
    else $error("unmapped read returned data");

  unmapped_write_a: assert property (seq_bad_write |-> pslverr
                                     ##1 ($stable(state_reg.calCfg)
                                     && $stable(state_reg.emuxCfg)))
    else $error("unmapped write not refused");

  status_ro_a: assert property (accessPhase && pwrite && paddr == CAL_STAT_ADDR
                                |-> !pslverr ##1 ($stable(state_reg.calCfg)
                                && $stable(state_reg.emuxCfg)))
    else $error("status write not ignored");

  rdata_hold_a: assert property (!setupPhase |=> $stable(prdata))
    else $error("read data changed outside setup");

  reserved_zero_a: assert property ((state_reg.calCfg & ~CAL_CFG_MASK) == '0
                                    && (state_reg.emuxCfg & ~EMUX_CFG_MASK) == '0)
    else $error("reserved register bits set");

  enable_follow_a: assert property (p_follow_bit(calEnBit, calSourceEnable))
    else $error("source enable does not follow register");

  tick_once_a: assert property (mclkTick |=> !mclkTick)
    else $error("master clock edge counted twice");

  unipolar_low_a: assert property (calEnBit && !calModeBit && !phaseHigh
                                   |=> calSourcePosLevel == LEVEL_MID
                                   && calSourceNegLevel == LEVEL_MID)
    else $error("unipolar rest level wrong");

  bipolar_phase_a: assert property (calEnBit && calModeBit && phaseHigh
                                    |=> calSourcePosLevel == LEVEL_PLUS
                                    && calSourceNegLevel == LEVEL_MINUS)
    else $error("bipolar high phase levels wrong");

endmodule : calmux_top

// >>> rtl/calmux_wave_gen.sv
// calibration square wave timing, counted in master clock ticks
`timescale 1ns/1ps
module calmux_wave_gen
  import calmux_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              enable,
  input  wire logic              tick,
  input  wire logic [FREQ_W-1:0] divSel,
  input  wire logic              halfDuty,
  input  wire logic [HIGH_W-1:0] highCount,
  output logic                   phaseHigh
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             high;
  } calmux_gen_st_t;

  calmux_gen_st_t   state_reg;
  calmux_gen_st_t   state_next;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] periodLast;
  logic [CNT_W-1:0] highTime;

  assign period     = CNT_W'(1) << FREQ_SHIFT[divSel];
  assign periodLast = period - CNT_W'(1);
  assign highTime   = halfDuty ? (period >> 1) : CNT_W'(highCount);

  always_comb begin
    state_next = state_reg;
    if (!enable) begin
      state_next.cnt = '0;
    end else if (tick) begin
      state_next.cnt = (state_reg.cnt >= periodLast) ? '0 : state_reg.cnt + CNT_W'(1);
    end
    state_next.high = enable && (state_next.cnt < highTime);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign phaseHigh = state_reg.high;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence seq_last_tick;
    enable && tick && state_reg.cnt == periodLast;
  endsequence

  sequence seq_half_edge;
    enable && halfDuty && tick && state_reg.cnt == (period >> 1) - CNT_W'(1);
  endsequence

  idle_held_a: assert property (!enable |=> state_reg.cnt == '0 && !phaseHigh)
    else $error("counter not held while disabled");
  period_wrap_a: assert property (seq_last_tick ##1 enable |-> state_reg.cnt == '0)
    else $error("period did not wrap at divider length");
  half_fall_a: assert property (seq_half_edge ##1 enable && halfDuty && $stable(divSel)
                                |-> !phaseHigh)
    else $error("half duty high time wrong");
  count_fall_a: assert property (enable && !halfDuty && tick && highCount != '0
                                 && state_reg.cnt == CNT_W'(highCount) - CNT_W'(1)
                                 && state_reg.cnt < periodLast
                                 ##1 enable && !halfDuty && $stable(highCount)
                                 |-> !phaseHigh)
    else $error("programmed high time wrong");

endmodule : calmux_wave_gen

// >>> tb/calmux_top_tb.sv
// self-checking bench for the calibration source and input mux block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module calmux_top_tb
  import calmux_pkg::*;
;
  logic              core_clk;
  logic              rstn;
  logic [APB_AW-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              masterClk;
  logic [1:0]        masterFreqSelect;
  logic              calSourceEnable;
  logic              calAmplitudeSelect;
  logic [1:0]        calSourcePosLevel;
  logic [1:0]        calSourceNegLevel;
  logic              inputInvert;
  logic              posInputIsolate;
  logic              negInputIsolate;
  logic [1:0]        posInputCalRoute;
  logic [1:0]        negInputCalRoute;
  int                numErrors   = 0;
  int                comparisons = 0;
  logic [31:0]       seed        = 32'hD4B2;
  logic [23:0]       calReg;
  logic [23:0]       muxReg;
  logic [31:0]       rdData;
  logic              rdErr;
  int                resNs [4]    = '{30520, 31250, 31250, 31280};
  logic [23:0]       waveCfg [4]  = '{24'h000800, 24'h200005, 24'h301800, 24'h000000};
  int                waveTicks [4] = '{132, 132, 516, 130};

  calmux_top i_calmux_top (
    .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .masterClk(masterClk), .masterFreqSelect(masterFreqSelect),
    .calSourceEnable(calSourceEnable), .calAmplitudeSelect(calAmplitudeSelect),
    .calSourcePosLevel(calSourcePosLevel), .calSourceNegLevel(calSourceNegLevel),
    .inputInvert(inputInvert), .posInputIsolate(posInputIsolate),
    .negInputIsolate(negInputIsolate), .posInputCalRoute(posInputCalRoute),
    .negInputCalRoute(negInputCalRoute)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    if (numErrors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  function automatic logic is_mapped(input logic [7:0] a);
    return a == CAL_CFG_ADDR || a == CAL_STAT_ADDR || a == EMUX_CFG_ADDR;
  endfunction : is_mapped

  // model of the source level after cnt master ticks since enable
  function automatic logic [1:0] exp_level(input logic pos, input int cnt);
    int period;
    int high;
    period = 1 << (7 + 2 * calReg[14:12]);
    high   = calReg[11] ? period / 2 : int'(calReg[10:0]);
    if (!calReg[22]) return LEVEL_MID;
    if ((cnt % period) < high) return pos ? LEVEL_PLUS : LEVEL_MINUS;
    if (calReg[21]) return pos ? LEVEL_MINUS : LEVEL_PLUS;
    return LEVEL_MID;
  endfunction : exp_level

  function automatic logic [1:0] exp_route(input logic [1:0] r);
    return (!calReg[22] && r[1]) ? ROUTE_NONE : r;
  endfunction : exp_route

  function automatic logic [31:0] exp_status(input int sel, input int cnt);
    logic ph;
    ph = exp_level(1'b1, cnt) == LEVEL_PLUS;
    return {9'h000, ph, exp_level(1'b0, cnt), exp_level(1'b1, cnt), sel[1:0],
            resNs[sel][15:0]};
  endfunction : exp_status

  // one apb transfer; starts at the next edge, ends just after the sampling edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      numErrors++;
      give_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic [31:0] r;
    r = xorshift();
    apb(a, 1'b1, {r[31:24], d});
    if (a == CAL_CFG_ADDR) calReg = d & CAL_CFG_MASK;
    if (a == EMUX_CFG_ADDR) muxReg = d & EMUX_CFG_MASK;
    `CHK(rdErr, !is_mapped(a))
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h00000000);
    `CHK(rdData, exp)
    `CHK(rdErr, !is_mapped(a))
  endtask : rd_chk

  task automatic check_outs(input int cnt);
    `CHK(calSourceEnable, calReg[22])
    `CHK(calAmplitudeSelect, calReg[20])
    `CHK(inputInvert, muxReg[23])
    `CHK(posInputIsolate, muxReg[21])
    `CHK(negInputIsolate, muxReg[20])
    `CHK(posInputCalRoute, exp_route(muxReg[19:18]))
    `CHK(negInputCalRoute, exp_route(muxReg[17:16]))
    `CHK(calSourcePosLevel, exp_level(1'b1, cnt))
    `CHK(calSourceNegLevel, exp_level(1'b0, cnt))
  endtask : check_outs

  // master clock pulses well apart, so each one is seen as a single tick
  task automatic run_wave(input logic [23:0] cfg, input int nTicks);
    wr(CAL_CFG_ADDR, cfg);
    repeat (4) @(posedge core_clk);
    check_outs(0);
    wr(CAL_CFG_ADDR, cfg | 24'h400000);
    repeat (4) @(posedge core_clk);
    check_outs(0);
    for (int i = 1; i <= nTicks; i++) begin
      masterClk <= 1'b1;
      repeat (10) @(posedge core_clk);
      masterClk <= 1'b0;
      repeat (10) @(posedge core_clk);
      check_outs(i);
    end
  endtask : run_wave

  initial begin
    logic [31:0] c;
    logic [31:0] m;
    rstn             = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 8'h00;
    pwdata           = 32'h00000000;
    masterClk        = 1'b0;
    masterFreqSelect = 2'h0;
    calReg           = 24'h004800;
    muxReg           = 24'h300000;
    repeat (8) @(posedge core_clk);
    check_outs(0);
    rstn <= 1'b1;
    rd_chk(CAL_CFG_ADDR, {8'h00, calReg});
    rd_chk(EMUX_CFG_ADDR, {8'h00, muxReg});
    for (int i = 0; i < 8; i++) begin
      c = xorshift();
      m = xorshift();
      masterFreqSelect <= i[1:0];
      wr(CAL_CFG_ADDR, c[23:0]);
      wr(EMUX_CFG_ADDR, m[23:0]);
      repeat (4) @(posedge core_clk);
      check_outs(0);
      rd_chk(CAL_CFG_ADDR, {8'h00, calReg});
      rd_chk(EMUX_CFG_ADDR, {8'h00, muxReg});
      rd_chk(CAL_STAT_ADDR, exp_status(i % 4, 0));
    end
    wr(8'h44, 24'hFFFFFF);
    wr(CAL_STAT_ADDR, 24'hFFFFFF);
    rd_chk(8'h44, 32'h00000000);
    rd_chk(CAL_CFG_ADDR, {8'h00, calReg});
    // isolate both inputs while sources are routed to them
    wr(EMUX_CFG_ADDR, 24'h3B0000);
    for (int k = 0; k < 4; k++) begin
      run_wave(waveCfg[k], waveTicks[k]);
    end
    rd_chk(CAL_STAT_ADDR, exp_status(3, waveTicks[3]));
    give_verdict();
  end
endmodule : calmux_top_tb
